// file: logic/slc_pkg.sv
// Constants shared by the switch link status and configuration block.
// Assumes word-indexed register addressing on the register bus.
package slc_pkg;

  // ---------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------
  localparam logic [7:0] REG_NODE_CONFIGURATION = 8'h04;
  localparam logic [7:0] REG_NODE_IDENTIFIER    = 8'h05;
  localparam logic [7:0] REG_PROC_LINK_STATUS_0 = 8'h40;
  localparam logic [7:0] REG_PROC_LINK_STATUS_3 = 8'h43;
  localparam logic [7:0] REG_EXT_LINK_CFG_FIRST = 8'h80;
  localparam logic [7:0] REG_EXT_LINK_CFG_LAST  = 8'h87;

  localparam int NUM_PLINKS    = 4;
  localparam int NUM_EXT_LINKS = 8;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int CFG_LOCK_BIT      = 31;
  localparam int CFG_HDR_MODE_BIT  = 0;
  localparam int PLS_KIND_LSB      = 24;
  localparam int PLS_DEST_LSB      = 16;
  localparam int PLS_NET_LSB       = 4;
  localparam int PLS_JUNK_BIT      = 2;
  localparam int PLS_ROUTE_IN_BIT  = 1;
  localparam int PLS_ROUTE_OUT_BIT = 0;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic        RST_LOCK     = 1'b0;
  localparam logic        RST_HDR_MODE = 1'b0;
  localparam logic [15:0] RST_NODE_ID  = 16'h0000;
  localparam logic [1:0]  RST_NET      = 2'h0;
  localparam logic [7:0]  RST_DEST     = 8'h00;
  localparam logic [1:0]  RST_KIND     = 2'h0;
  localparam logic [31:0] RST_EXT_CFG  = 32'h0000_0000;

  // Kind of link that inbound data is routed to.
  typedef enum logic [1:0] {
    SLC_KIND_PROC     = 2'b00,
    SLC_KIND_EXTERNAL = 2'b01,
    SLC_KIND_CONTROL  = 2'b10
  } slc_kind_e;

endpackage

// file: logic/slc_plink.sv
// One processor-link status and network register.
// Assumes status inputs come from switch logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module slc_plink
  import slc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        net_wr,
  input  wire logic [1:0]  net_wdata,
  input  wire logic [1:0]  route_kind,
  input  wire logic [7:0]  route_dest,
  input  wire logic        junk,
  input  wire logic        route_in,
  input  wire logic        route_out,
  output logic      [31:0] status_word,
  output logic      [1:0]  net
);

  typedef struct packed {
    logic [1:0] kind;
    logic [7:0] dest;
    logic [1:0] net;
    logic       junk;
    logic       route_in;
    logic       route_out;
  } slc_plink_s;

  slc_plink_s st_ff;
  slc_plink_s nxt_st;

  always_comb begin
    nxt_st           = st_ff;
    // The destination and kind only mean something while routing out into the switch, so they hold otherwise.
    if (route_out) begin
      nxt_st.kind = route_kind;
      nxt_st.dest = route_dest;
    end
    nxt_st.junk      = junk;
    nxt_st.route_in  = route_in;
    nxt_st.route_out = route_out;
    if (net_wr) begin
      nxt_st.net = net_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_ff <= '{kind: RST_KIND, dest: RST_DEST, net: RST_NET,
                 junk: 1'b0, route_in: 1'b0, route_out: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_comb begin
    status_word                                   = 32'h0000_0000;
    status_word[PLS_KIND_LSB +: 2]                = st_ff.kind;
    status_word[PLS_DEST_LSB +: 8]                = st_ff.dest;
    status_word[PLS_NET_LSB +: 2]                 = st_ff.net;
    status_word[PLS_JUNK_BIT]                     = st_ff.junk;
    status_word[PLS_ROUTE_IN_BIT]                 = st_ff.route_in;
    status_word[PLS_ROUTE_OUT_BIT]                = st_ff.route_out;
  end

  assign net = st_ff.net;

endmodule

`default_nettype wire

// file: logic/slc_top.sv
// Switch node configuration and link status registers behind an Avalon-MM slave.
// Assumes switch status inputs are synchronous to clk; address is a word index.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - each processor-link status shows kind of link data routes to, two bits.
// - eight-bit destination link number while routing into switch, resets to zero.
// - two-bit read-write quality-of-service network per processor link, resets zero.
// - status bit set while the current packet is being discarded as junk.
// - status bit set while switch delivers data into this link from another.
// - status bit set while link sends into switch over a created route.
// - four processor-link status registers at consecutive indices 0x40 to 0x43.
// - eight external-link registers 0x80..0x87 map to links C,D,A,B,G,H,E,F.
// - writing one to configuration bit 31 blocks configuration and link writes.
// - configuration bit zero selects header length, 0 three-byte, 1 one-byte.
// - node identifier holds sixteen read-write bits low, upper half reads zero.
module slc_top
  import slc_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [7:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  input  wire logic [3:0]   avs_byteenable,
  output logic      [31:0]  avs_readdata,
  output logic              avs_waitrequest,
  input  wire logic [7:0]   plink_route_kind,
  input  wire logic [31:0]  plink_route_dest,
  input  wire logic [3:0]   plink_junk,
  input  wire logic [3:0]   plink_route_in,
  input  wire logic [3:0]   plink_route_out,
  output logic      [7:0]   plink_net,
  output logic              cfg_locked,
  output logic              hdr_one_byte,
  output logic      [15:0]  node_id,
  output logic      [255:0] ext_link_cfg
);

  // ---------------------------------------------------------------------
  // Address decoding
  // ---------------------------------------------------------------------
  function automatic logic is_plink(input logic [7:0] a);
    is_plink = (a >= REG_PROC_LINK_STATUS_0) && (a <= REG_PROC_LINK_STATUS_3);
  endfunction

  function automatic logic is_ext(input logic [7:0] a);
    is_ext = (a >= REG_EXT_LINK_CFG_FIRST) && (a <= REG_EXT_LINK_CFG_LAST);
  endfunction

  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    merge_be = r;
  endfunction

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic                    waitreq;
    logic [31:0]             rdata;
    logic                    lock;
    logic                    hdr_mode;
    logic [15:0]             node_id;
    logic [7:0][31:0]        ext_cfg;
  } slc_top_s;

  slc_top_s st_ff;
  slc_top_s nxt_st;

  logic [NUM_PLINKS-1:0][31:0] plink_word;
  logic [NUM_PLINKS-1:0]       plink_wr;
  logic [7:0]                  net_q;
  logic                        req;
  logic                        commit_wr;
  logic [1:0]                  plink_sel;
  logic [2:0]                  ext_sel;

  // A request commits on the edge where the master sees waitrequest low.
  assign req       = avs_read || avs_write;
  assign commit_wr = avs_write && !st_ff.waitreq;
  assign plink_sel = avs_address[1:0];
  assign ext_sel   = avs_address[2:0];

  // ---------------------------------------------------------------------
  // Processor-link registers
  // ---------------------------------------------------------------------
  for (genvar i = 0; i < NUM_PLINKS; i++) begin : g_plink
    // Network field lives in byte 0; a locked node ignores the write.
    assign plink_wr[i] = commit_wr && is_plink(avs_address) && (plink_sel == 2'(i)) &&
                         avs_byteenable[0] && !st_ff.lock;

    slc_plink u_plink (
      .clk         (clk),
      .nrst        (nrst),
      .net_wr      (plink_wr[i]),
      .net_wdata   (avs_writedata[PLS_NET_LSB +: 2]),
      .route_kind  (plink_route_kind[i*2 +: 2]),
      .route_dest  (plink_route_dest[i*8 +: 8]),
      .junk        (plink_junk[i]),
      .route_in    (plink_route_in[i]),
      .route_out   (plink_route_out[i]),
      .status_word (plink_word[i]),
      .net         (net_q[i*2 +: 2])
    );
  end

  // ---------------------------------------------------------------------
  // Bus slave and node configuration
  // ---------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    // One wait state: first edge latches read data, second edge completes.
    if (req && st_ff.waitreq) begin
      nxt_st.waitreq = 1'b0;
      nxt_st.rdata   = 32'h0000_0000;
      if (avs_address == REG_NODE_CONFIGURATION) begin
        nxt_st.rdata[CFG_LOCK_BIT]     = st_ff.lock;
        nxt_st.rdata[CFG_HDR_MODE_BIT] = st_ff.hdr_mode;
      end else if (avs_address == REG_NODE_IDENTIFIER) begin
        nxt_st.rdata[15:0] = st_ff.node_id;
      end else if (is_plink(avs_address)) begin
        nxt_st.rdata = plink_word[plink_sel];
      end else if (is_ext(avs_address)) begin
        nxt_st.rdata = st_ff.ext_cfg[ext_sel];
      end
    end else begin
      nxt_st.waitreq = 1'b1;
    end

    // Writes are refused silently while locked; unmapped writes are dropped.
    if (commit_wr && !st_ff.lock) begin
      if (avs_address == REG_NODE_CONFIGURATION) begin
        if (avs_byteenable[0]) begin
          nxt_st.hdr_mode = avs_writedata[CFG_HDR_MODE_BIT];
        end
        if (avs_byteenable[3] && avs_writedata[CFG_LOCK_BIT]) begin
          nxt_st.lock = 1'b1;
        end
      end else if (avs_address == REG_NODE_IDENTIFIER) begin
        nxt_st.node_id = 16'(merge_be({16'h0000, st_ff.node_id}, avs_writedata,
                                      avs_byteenable));
      end else if (is_ext(avs_address)) begin
        nxt_st.ext_cfg[ext_sel] = merge_be(st_ff.ext_cfg[ext_sel], avs_writedata,
                                           avs_byteenable);
      end
    end
    // The lock is only ever set; nothing short of reset clears it.
    if (st_ff.lock) begin
      nxt_st.lock = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_ff.waitreq  <= 1'b1;
      st_ff.rdata    <= 32'h0000_0000;
      st_ff.lock     <= RST_LOCK;
      st_ff.hdr_mode <= RST_HDR_MODE;
      st_ff.node_id  <= RST_NODE_ID;
      st_ff.ext_cfg  <= {NUM_EXT_LINKS{RST_EXT_CFG}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  assign avs_readdata    = st_ff.rdata;
  assign avs_waitrequest = st_ff.waitreq;
  assign cfg_locked      = st_ff.lock;
  assign hdr_one_byte    = st_ff.hdr_mode;
  assign node_id         = st_ff.node_id;
  assign ext_link_cfg    = st_ff.ext_cfg;
  assign plink_net       = net_q;

endmodule

`default_nettype wire

// file: tb/slc_far_model.sv
// Far-side switch links reporting routing state for four processor links.
// Assumes the bench loads a new state word; outputs change only at a clock edge.
`timescale 1ns/1ps
`default_nettype none
module slc_far_model
  import slc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        ld,
  input  wire logic [51:0] nv,
  output var logic  [7:0]  route_kind,
  output var logic  [31:0] route_dest,
  output var logic  [3:0]  junk,
  output var logic  [3:0]  route_in,
  output var logic  [3:0]  route_out
);
  initial {route_kind, route_dest, junk, route_in, route_out} = '0;
  always @(posedge clk) begin
    if (ld) {route_kind, route_dest, junk, route_in, route_out} <= nv;
  end
endmodule
`default_nettype wire

// file: tb/slc_sva.sv
// Assertions on the switch node configuration and link status registers.
// Assumes binding to slc_top; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module slc_sva
  import slc_pkg::*;
(
  input wire logic         clk,
  input wire logic         nrst,
  input wire logic [7:0]   avs_address,
  input wire logic         avs_read,
  input wire logic         avs_write,
  input wire logic [31:0]  avs_writedata,
  input wire logic [3:0]   avs_byteenable,
  input wire logic [31:0]  avs_readdata,
  input wire logic         avs_waitrequest,
  input wire logic [7:0]   plink_net,
  input wire logic         cfg_locked,
  input wire logic         hdr_one_byte,
  input wire logic [15:0]  node_id,
  input wire logic [255:0] ext_link_cfg
);
  // ------------------------------------------------------------
  // Commit points
  // ------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic wr, rd;
  assign wr = avs_write && !avs_waitrequest && !cfg_locked;
  assign rd = avs_read && !avs_waitrequest;
  a_lock_sticky: assert property (cfg_locked |=> cfg_locked)
    else $error("lock cleared");
  a_lock_set: assert property (wr && avs_address == REG_NODE_CONFIGURATION
    && avs_byteenable[3] && avs_writedata[31] |=> cfg_locked) else $error("lock not set");
  a_hdr_write: assert property (wr && avs_address == REG_NODE_CONFIGURATION
    && avs_byteenable[0] |=> hdr_one_byte == $past(avs_writedata[0])) else $error("hdr");
  a_id_write: assert property (wr && avs_address == REG_NODE_IDENTIFIER
    && avs_byteenable == 4'hf |=> node_id == $past(avs_writedata[15:0])) else $error("id");
  a_ext_write: assert property (wr && avs_address == REG_EXT_LINK_CFG_FIRST
    && avs_byteenable == 4'hf |=> ext_link_cfg[31:0] == $past(avs_writedata)) else $error("ext");
  a_lock_freeze: assert property (cfg_locked |=> $stable(hdr_one_byte)
    && $stable(node_id) && $stable(plink_net) && $stable(ext_link_cfg))
    else $error("write while locked");
  a_id_upper: assert property (rd && avs_address == REG_NODE_IDENTIFIER
    |-> avs_readdata[31:16] == 16'h0) else $error("id upper half");
  a_net_read: assert property (rd && avs_address[7:2] == 6'h10 |->
    avs_readdata[5:4] == plink_net[{avs_address[1:0], 1'b0} +: 2]) else $error("net read");
  a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait state count");
  a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
endmodule
bind slc_top slc_sva i_sva (.clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_byteenable, .avs_readdata, .avs_waitrequest, .plink_net, .cfg_locked, .hdr_one_byte,
  .node_id, .ext_link_cfg);
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench: register model against slc_top over Avalon-MM.
// Assumes a word-indexed slave and one 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import slc_pkg::*;
;
  logic         clk, nrst, avs_read, avs_write, avs_waitrequest, cfg_locked, hdr_one_byte, ld;
  logic [7:0]   avs_address, plink_route_kind, plink_net, a;
  logic [31:0]  avs_writedata, avs_readdata, plink_route_dest, rnd, got, mreg [256];
  logic [3:0]   avs_byteenable, plink_junk, plink_route_in, plink_route_out;
  logic [15:0]  node_id;
  logic [255:0] ext_link_cfg;
  logic [51:0]  nv;
  logic [9:0]   lat [4];
  int           fails, checked;
  slc_top i_dut (.clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .plink_route_kind, .plink_route_dest,
    .plink_junk, .plink_route_in, .plink_route_out, .plink_net, .cfg_locked, .hdr_one_byte,
    .node_id, .ext_link_cfg);
  slc_far_model i_far (.clk, .ld, .nv, .route_kind(plink_route_kind),
    .route_dest(plink_route_dest), .junk(plink_junk), .route_in(plink_route_in),
    .route_out(plink_route_out));
  // ------------------------------------------------------------
  // Model and bus tasks
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] wmask(input logic [7:0] x);
    if (x == REG_NODE_CONFIGURATION) return 32'h8000_0001;
    if (x == REG_NODE_IDENTIFIER) return 32'h0000_ffff;
    if (x[7:2] == 6'h10) return 32'h0000_0030;
    if (x[7:3] == 5'h10) return 32'hffff_ffff;
    return 32'h0;
  endfunction
  task automatic results();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] ba, input logic [31:0] d,
                     input logic [3:0] b);
    int n;
    logic [31:0] m;
    @(posedge clk);
    {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} <= {!w, w, ba, d, b};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      fails++;
      results();
    end
    got = avs_readdata;
    {avs_read, avs_write} <= 2'b00;
    m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}} & wmask(ba);
    if (w && !mreg[4][31]) mreg[ba] = (mreg[ba] & ~m) | (d & m);
  endtask
  task automatic rdchk(input logic [7:0] ra);
    bus(1'b0, ra, 32'h0, 4'h0);
    chk(got, mreg[ra] | ((ra[7:2] == 6'h10) ? {6'h0, lat[ra[1:0]], 13'h0,
      plink_junk[ra[1:0]], plink_route_in[ra[1:0]], plink_route_out[ra[1:0]]} : 32'h0));
  endtask
  task automatic portchk();
    #1;
    chk(32'(node_id), 32'(mreg[5][15:0]));
    chk(32'(hdr_one_byte), 32'(mreg[4][0]));
    chk(32'(cfg_locked), 32'(mreg[4][31]));
    for (int i = 0; i < 4; i++) chk(32'(plink_net[2*i +: 2]), 32'(mreg[64+i][5:4]));
    for (int k = 0; k < 8; k++) chk(ext_link_cfg[32*k +: 32], mreg[128+k]);
  endtask
  task automatic randwr(input int n);
    int r;
    repeat (n) begin
      rnd = lfsr(rnd);
      r = rnd[31:24] % 14;
      a = (r == 0) ? REG_NODE_IDENTIFIER : (r < 5) ? 8'(63 + r) : (r < 13) ? 8'(123 + r) : 8'h3c;
      bus(1'b1, a, rnd, rnd[3:0]);
      rdchk(a);
      portchk();
    end
  endtask
  task automatic drive_links();
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      nv[44 + 2*i +: 2] = 2'(rnd[7:0] % 8'd3);
      nv[12 + 8*i +: 8] = rnd[15:8];
      {nv[8 + i], nv[4 + i], nv[i]} = rnd[18:16];
      if (nv[i]) lat[i] = {nv[44 + 2*i +: 2], nv[12 + 8*i +: 8]};
    end
    ld <= 1'b1;
    @(posedge clk);
    ld <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {nrst, avs_read, avs_write, avs_address, avs_writedata, avs_byteenable, ld, nv} = '0;
    {fails, checked} = '0;
    rnd = 32'h8480;
    foreach (mreg[i]) mreg[i] = '0;
    foreach (lat[i]) lat[i] = '0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 256; i++) rdchk(8'(i));
    for (int k = 0; k < 9; k++) begin
      rnd = lfsr(rnd);
      bus(1'b1, (k == 8) ? REG_NODE_IDENTIFIER : 8'(128 + k), rnd, 4'hf);
      portchk();
    end
    bus(1'b1, REG_NODE_CONFIGURATION, 32'h1, 4'h1);
    rdchk(REG_NODE_CONFIGURATION);
    randwr(40);
    repeat (12) begin
      drive_links();
      for (int i = 64; i < 68; i++) rdchk(8'(i));
    end
    bus(1'b1, REG_NODE_CONFIGURATION, 32'h8000_0000, 4'h8);
    randwr(20);
    bus(1'b1, REG_NODE_CONFIGURATION, 32'h0, 4'hf);
    rdchk(REG_NODE_CONFIGURATION);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    foreach (mreg[i]) mreg[i] = '0;
    portchk();
    rdchk(REG_NODE_CONFIGURATION);
    bus(1'b1, REG_NODE_IDENTIFIER, 32'h0000_5a3c, 4'h3);
    rdchk(REG_NODE_IDENTIFIER);
    portchk();
    results();
  end
endmodule
`default_nettype wire
